// ==== flash_boot_loader_ram_overlay.v ====
/*
 * Boot-mode serial loader with auto-baud, plus flash RAM overlay decode.
 * Assumes an external flash controller answers erase/blank handshakes
 * and a RAM answers the write port; all inputs synchronous to clk.
 */
`timescale 1ns/1ps
`include "flash_boot_regs.vh"

// Notes on behaviour
// - Boot mode at reset release starts the loader instead of user code.
// - Device times low interval of 00 bytes and loads the baud divisor.
// - After matching, device sends one 00 byte as completion mark.
// - On 55 the device replies with one AA.
// - Device echoes both length bytes in order received.
// - Program bytes sent N times; device echoes each and stores sequentially.
// - Device checks flash, erases if written, sends AA, or FF and halts.
// - After AA the device jumps to the loaded RAM program.
// - Overlay RAM is always the fixed 4-kbyte window at FFFFE000.
// - Overlaid flash block is one of blocks zero to seven by select field.
// - While active, overlay RAM answers at RAM and selected flash addresses.
// - Overlay enabled blocks all flash program and erase requests.
// - Clearing overlay enable returns selected block accesses to flash.
// - Software erase never erases the overlay RAM contents.
// - Overlay works in user mode and user program mode.
// - Flash reads blocked while a program or erase runs.
// - Select value n maps block n at n times 0x1000.
// - Serial framing is eight data bits, one stop, no parity.
// - Before jump, receive and transmit off, divisor kept, transmit pin high.
module flash_boot_loader_ram_overlay #(
    parameter DIV_W = 16,
    parameter LEN_W = 16,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
) (
    input wire clk,
    input wire rst,
    input wire boot_mode,
    input wire rxd,
    output reg txd,
    output wire [DIV_W-1:0] baud_divisor_register,
    output wire serial_receive_enable,
    output wire serial_transmit_enable,
    output wire [31:0] ram_wr_addr,
    output wire [7:0] ram_wr_data,
    output wire ram_wr_valid,
    input wire ram_wr_ready,
    output wire flash_blank_check,
    input wire flash_blank_done,
    input wire flash_written,
    output wire flash_erase_all,
    input wire flash_erase_done,
    input wire flash_erase_ok,
    output wire jump_to_ram,
    output wire [31:0] jump_addr,
    output wire boot_failed,
    input wire [3:0] overlay_control_register,
    input wire [31:0] cpu_addr,
    output wire [31:0] mapped_addr,
    output wire overlay_hit,
    input wire prog_req,
    input wire erase_req,
    input wire flash_busy,
    output wire flash_program_go,
    output wire flash_erase_go,
    output wire flash_read_allow
);
    ////////////////////////////////////////////////////////////////////////
    // Loader states
    localparam [10:0] S_IDLE = 11'h001;
    localparam [10:0] S_BAUD = 11'h002;
    localparam [10:0] S_ACK0 = 11'h004;
    localparam [10:0] S_SYNC = 11'h008;
    localparam [10:0] S_LENH = 11'h010;
    localparam [10:0] S_LENL = 11'h020;
    localparam [10:0] S_DATA = 11'h040;
    localparam [10:0] S_BLANK = 11'h080;
    localparam [10:0] S_ERASE = 11'h100;
    localparam [10:0] S_DONE = 11'h200;
    localparam [10:0] S_FAIL = 11'h400;

    reg [10:0] state_q;
    reg [DIV_W-1:0] div_q;
    reg [DIV_W+3:0] low_cnt_q;
    reg rxd_prev_q;
    reg [LEN_W-1:0] len_q;
    reg [LEN_W-1:0] count_q;
    reg [31:0] wptr_q;
    reg flash_req_q;
    reg jump_q;
    reg fail_q;
    reg serial_on_q;

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    reg [2:0] rx_st_q;
    reg [DIV_W-1:0] rx_cnt_q;
    reg [3:0] rx_bit_q;
    reg [7:0] rx_sh_q;
    reg [7:0] rx_byte_q;
    reg rx_strobe_q;
    localparam [2:0] RX_IDLE = 3'h1;
    localparam [2:0] RX_BITS = 3'h2;
    localparam [2:0] RX_STOP = 3'h4;

    // Middle-of-bit sampling; start bit not rechecked at half a bit
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_st_q <= RX_IDLE;
            rx_cnt_q <= {DIV_W{1'b0}};
            rx_bit_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_byte_q <= 8'h00;
            rx_strobe_q <= 1'b0;
        end else begin
            rx_strobe_q <= 1'b0;
            case (rx_st_q)
                RX_IDLE: begin
                    rx_bit_q <= 4'h0;
                    if (serial_on_q && state_q != S_BAUD && !rxd) begin
                        rx_st_q <= RX_BITS;
                        rx_cnt_q <= div_q >> 1;
                    end
                end
                RX_BITS: begin
                    if (rx_cnt_q == {DIV_W{1'b0}}) begin
                        rx_cnt_q <= div_q;
                        if (rx_bit_q != 4'h0) begin
                            rx_sh_q <= {rxd, rx_sh_q[7:1]};
                        end
                        rx_bit_q <= rx_bit_q + 4'h1;
                        if (rx_bit_q == 4'h8) begin
                            rx_st_q <= RX_STOP;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 1'b1;
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_q == {DIV_W{1'b0}}) begin
                        rx_st_q <= RX_IDLE;
                        // Framing errors are dropped; host then resets
                        if (rxd) begin
                            rx_byte_q <= rx_sh_q;
                            rx_strobe_q <= 1'b1;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 1'b1;
                    end
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit FIFO absorbs echo bursts while the line is busy
    reg [7:0] tx_push_data;
    reg tx_push;
    wire tx_in_ready;
    wire [7:0] tx_fifo_data;
    wire tx_fifo_valid;
    wire tx_fifo_pop;
    reg tx_busy_q;
    reg [9:0] tx_sh_q;
    reg [3:0] tx_bit_q;
    reg [DIV_W-1:0] tx_cnt_q;

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_tx_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(tx_push_data),
        .in_valid(tx_push),
        .in_ready(tx_in_ready),
        .out_data(tx_fifo_data),
        .out_valid(tx_fifo_valid),
        .out_ready(tx_fifo_pop)
    );

    assign tx_fifo_pop = !tx_busy_q && serial_on_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_busy_q <= 1'b0;
            tx_sh_q <= 10'h3FF;
            tx_bit_q <= 4'h0;
            tx_cnt_q <= {DIV_W{1'b0}};
            txd <= 1'b1;
        end else if (!tx_busy_q) begin
            txd <= 1'b1;
            if (tx_fifo_valid && serial_on_q) begin
                tx_busy_q <= 1'b1;
                tx_sh_q <= {1'b1, tx_fifo_data, 1'b0};
                tx_bit_q <= 4'h0;
                tx_cnt_q <= {DIV_W{1'b0}};
            end
        end else if (tx_cnt_q == {DIV_W{1'b0}}) begin
            txd <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_cnt_q <= div_q;
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == 4'hA) begin
                tx_busy_q <= 1'b0;
                txd <= 1'b1;
            end
        end else begin
            tx_cnt_q <= tx_cnt_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loader sequence
    wire rx_fall;
    wire rx_rise;
    localparam [DIV_W+3:0] LOW_BITS = `BITS_IN_LOW;
    localparam [DIV_W+3:0] LOW_HALF = `BITS_IN_LOW / 2;
    wire [DIV_W+3:0] div_calc;
    wire store_ok;
    assign rx_fall = rxd_prev_q && !rxd;
    assign rx_rise = !rxd_prev_q && rxd;
    // Divisor = clocks per bit minus one, rounded to nearest
    assign div_calc = (low_cnt_q + LOW_HALF) / LOW_BITS;
    // Pointer and count advance only when echo FIFO and RAM are both ready
    assign store_ok = tx_in_ready && ram_wr_ready;

    always @* begin
        tx_push = 1'b0;
        tx_push_data = rx_byte_q;
        case (state_q)
            S_ACK0: begin
                tx_push = 1'b1;
                tx_push_data = `BYTE_ADJUST;
            end
            S_SYNC: begin
                tx_push = rx_strobe_q && rx_byte_q == `BYTE_SYNC_REQ;
                tx_push_data = `BYTE_ACK;
            end
            S_LENH, S_LENL: tx_push = rx_strobe_q;
            S_DATA: tx_push = rx_strobe_q;
            S_BLANK: begin
                tx_push = flash_blank_done && !flash_written;
                tx_push_data = `BYTE_ACK;
            end
            S_ERASE: begin
                tx_push = flash_erase_done;
                tx_push_data = flash_erase_ok ? `BYTE_ACK : `BYTE_FAIL;
            end
            default: tx_push = 1'b0;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            div_q <= `BAUD_DIV_RESET;
            low_cnt_q <= {(DIV_W+4){1'b0}};
            rxd_prev_q <= 1'b1;
            len_q <= {LEN_W{1'b0}};
            count_q <= {LEN_W{1'b0}};
            wptr_q <= `BOOT_RAM_BASE;
            flash_req_q <= 1'b0;
            jump_q <= 1'b0;
            fail_q <= 1'b0;
            serial_on_q <= 1'b0;
        end else begin
            rxd_prev_q <= rxd;
            case (state_q)
                S_IDLE: begin
                    if (boot_mode) begin
                        state_q <= S_BAUD;
                        serial_on_q <= 1'b1;
                    end
                end
                S_BAUD: begin
                    // Host keeps sending 00 meanwhile
                    if (rx_fall) begin
                        low_cnt_q <= {(DIV_W+4){1'b0}};
                    end else if (!rxd) begin
                        low_cnt_q <= low_cnt_q + 1'b1;
                    end else if (rx_rise && low_cnt_q > 36) begin
                        div_q <= div_calc[DIV_W-1:0] - 1'b1;
                        state_q <= S_ACK0;
                    end
                end
                S_ACK0: state_q <= S_SYNC;
                S_SYNC: begin
                    if (rx_strobe_q && rx_byte_q == `BYTE_SYNC_REQ) begin
                        state_q <= S_LENH;
                    end
                end
                S_LENH: begin
                    if (rx_strobe_q) begin
                        len_q[LEN_W-1:8] <= rx_byte_q;
                        state_q <= S_LENL;
                    end
                end
                S_LENL: begin
                    if (rx_strobe_q) begin
                        len_q[7:0] <= rx_byte_q;
                        count_q <= {LEN_W{1'b0}};
                        if ({len_q[LEN_W-1:8], rx_byte_q} == {LEN_W{1'b0}}) begin
                            state_q <= S_BLANK;
                            flash_req_q <= 1'b1;
                        end else begin
                            state_q <= S_DATA;
                        end
                    end
                end
                S_DATA: begin
                    if (rx_strobe_q && store_ok) begin
                        wptr_q <= wptr_q + 32'h00000001;
                        count_q <= count_q + 1'b1;
                        if (count_q + 1'b1 == len_q) begin
                            state_q <= S_BLANK;
                            flash_req_q <= 1'b1;
                        end
                    end
                end
                S_BLANK: begin
                    if (flash_blank_done) begin
                        if (flash_written) begin
                            state_q <= S_ERASE;
                        end else begin
                            state_q <= S_DONE;
                            flash_req_q <= 1'b0;
                        end
                    end
                end
                S_ERASE: begin
                    if (flash_erase_done) begin
                        flash_req_q <= 1'b0;
                        state_q <= flash_erase_ok ? S_DONE : S_FAIL;
                    end
                end
                S_DONE: begin
                    // Let the final AA drain before shutting the channel
                    if (tx_fifo_valid == 1'b0 && !tx_busy_q) begin
                        serial_on_q <= 1'b0;
                        jump_q <= 1'b1;
                    end
                end
                S_FAIL: fail_q <= 1'b1;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    assign baud_divisor_register = div_q;
    assign serial_receive_enable = serial_on_q;
    assign serial_transmit_enable = serial_on_q;
    assign ram_wr_addr = wptr_q;
    assign ram_wr_data = rx_byte_q;
    assign ram_wr_valid = state_q == S_DATA && rx_strobe_q && tx_in_ready;
    assign flash_blank_check = flash_req_q && state_q == S_BLANK;
    assign flash_erase_all = flash_req_q && state_q == S_ERASE;
    assign jump_to_ram = jump_q;
    assign jump_addr = `BOOT_RAM_BASE;
    assign boot_failed = fail_q;

    ////////////////////////////////////////////////////////////////////////
    // RAM overlay, usable in any run mode
    function in_block;
        input [31:0] addr;
        input [2:0] sel;
        begin
            in_block = addr[31:15] == 17'h00000 && addr[14:12] == sel;
        end
    endfunction

    wire ovl_on;
    wire [2:0] ovl_sel;
    assign ovl_on = overlay_control_register[`OVL_ENABLE_BIT];
    assign ovl_sel = overlay_control_register[`OVL_SEL_MSB:`OVL_SEL_LSB];
    assign overlay_hit = ovl_on && in_block(cpu_addr, ovl_sel);
    // Window base fixed regardless of selected block
    assign mapped_addr = overlay_hit ? (`OVL_RAM_BASE | {20'h00000, cpu_addr[11:0]})
                                     : cpu_addr;
    // Erase path only reaches flash, never overlay RAM
    assign flash_program_go = prog_req && !ovl_on;
    assign flash_erase_go = erase_req && !ovl_on;
    assign flash_read_allow = !flash_busy;
endmodule

// ==== flash_boot_regs.vh ====
/*
 * Shared constants for the boot loader and RAM overlay block.
 * Assumes a 50 MHz system clock; included by bare name.
 */
`ifndef FLASH_BOOT_REGS_VH
`define FLASH_BOOT_REGS_VH

`define CLK_HZ 50000000
`define BYTE_ADJUST 8'h00
`define BYTE_SYNC_REQ 8'h55
`define BYTE_ACK 8'hAA
`define BYTE_FAIL 8'hFF
`define BITS_IN_LOW 9
`define OVL_RAM_BASE 32'hFFFFE000
`define OVL_RAM_LAST 32'hFFFFEFFF
`define OVL_BLOCK_BYTES 32'h00001000
`define OVL_SEL_LSB 0
`define OVL_SEL_MSB 2
`define OVL_ENABLE_BIT 3
`define OVL_CTRL_RESET 4'h0
`define BAUD_DIV_RESET 16'h0000
`define BOOT_RAM_BASE 32'hFFFFE800

`endif

// ==== byte_fifo.v ====
/*
 * Synchronous FIFO with valid/ready on both sides, flip-flop storage.
 * Assumes one clock; depth is a power of two.
 */
`timescale 1ns/1ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire push;
    wire pop;
    integer i;
    localparam [AW:0] FULL_COUNT = DEPTH;

    assign in_ready = (wr_q - rd_q) != FULL_COUNT;
    assign out_valid = wr_q != rd_q;
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_q[wr_q[AW-1:0]] <= in_data;
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

// ==== boot_checker_assertions.sv ====
/*
 * Port-level assertions for the boot loader and RAM overlay block.
 * Assumes one clock, reset active high, and a bind from the bench.
 */
`timescale 1ns/1ps
`include "flash_boot_regs.vh"
module boot_checker #(
    parameter DIV_W = 16
) (
    input wire clk,
    input wire rst,
    input wire txd,
    input wire [DIV_W-1:0] baud_divisor_register,
    input wire serial_receive_enable,
    input wire serial_transmit_enable,
    input wire [31:0] ram_wr_addr,
    input wire ram_wr_valid,
    input wire flash_erase_all,
    input wire flash_erase_done,
    input wire jump_to_ram,
    input wire [31:0] jump_addr,
    input wire [3:0] overlay_control_register,
    input wire [31:0] cpu_addr,
    input wire [31:0] mapped_addr,
    input wire overlay_hit,
    input wire prog_req,
    input wire erase_req,
    input wire flash_busy,
    input wire flash_program_go,
    input wire flash_erase_go,
    input wire flash_read_allow
);
    logic [31:0] prev_q;
    logic seen_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Remembers the last store address so each store can be tied to the one before
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_q <= 1'b0;
            prev_q <= 32'h00000000;
        end else if (ram_wr_valid) begin
            seen_q <= 1'b1;
            prev_q <= ram_wr_addr;
        end
    end
    ////////////////////////////////////////////////////////////
    prog_gate_a: assert property (
        flash_program_go == (prog_req && !overlay_control_register[3]))
        else $error("program start not gated by overlay enable");
    erase_gate_a: assert property (
        flash_erase_go == (erase_req && !overlay_control_register[3]))
        else $error("erase start not gated by overlay enable");
    read_block_a: assert property (flash_busy |-> !flash_read_allow)
        else $error("flash read allowed while busy");
    block_map_a: assert property (overlay_control_register[3] &&
        cpu_addr[31:15] == 17'h00000 && cpu_addr[14:12] == overlay_control_register[2:0]
        |-> overlay_hit && mapped_addr == {20'hFFFFE, cpu_addr[11:0]})
        else $error("selected block not mapped into overlay RAM");
    ram_window_a: assert property (overlay_control_register[3] &&
        cpu_addr[31:12] == 20'hFFFFE |-> mapped_addr == cpu_addr)
        else $error("overlay RAM not reachable at its own address");
    ovl_off_a: assert property (!overlay_control_register[3]
        |-> !overlay_hit && mapped_addr == cpu_addr)
        else $error("overlay active while disabled");
    ram_addr_a: assert property (ram_wr_valid
        |-> ram_wr_addr == (seen_q ? prev_q + 32'h00000001 : `BOOT_RAM_BASE))
        else $error("program store address out of sequence");
    jump_state_a: assert property (jump_to_ram [*3] |-> jump_addr == `BOOT_RAM_BASE &&
        !serial_receive_enable && !serial_transmit_enable && txd)
        else $error("jump state wrong");
    jump_hold_a: assert property (
        jump_to_ram |=> jump_to_ram && $stable(baud_divisor_register))
        else $error("divisor or jump not held");
    erase_hold_a: assert property (
        flash_erase_all && !flash_erase_done |=> flash_erase_all)
        else $error("erase request dropped early");
endmodule

// ==== serial_host_model.sv ====
/*
 * Behavioural host computer on the far side of the boot serial link.
 * Assumes idle-high lines and callers that start on a clock edge.
 */
`timescale 1ns/1ps
module serial_host_model #(
    parameter int BIT_NS = 800
) (
    output logic rxd,
    input wire txd
);
    logic [7:0] rx_q[$];
    logic [7:0] b;
    initial rxd = 1'b1;
    // Bit rate far above the supported host rates only to keep runs short
    task send_byte(input logic [7:0] v);
        rxd = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++) begin
            rxd = v[i];
            #(BIT_NS);
        end
        rxd = 1'b1;
        #(BIT_NS);
    endtask
    task sync_rate;
        for (int i = 0; i < 20 && rx_q.size() == 0; i++) begin
            send_byte(8'h00);
        end
    endtask
    // A frame with a bad stop bit is kept as unknown so that it never matches
    always begin
        @(negedge txd);
        #(BIT_NS * 3 / 2);
        for (int i = 0; i < 8; i++) begin
            b[i] = txd;
            #(BIT_NS);
        end
        rx_q.push_back(txd ? b : 8'hXX);
    end
endmodule

// ==== flash_boot_loader_ram_overlay_tb.sv ====
/*
 * Self-checking bench for the boot loader and RAM overlay block.
 * Assumes the serial host model; a flash stub and RAM monitor live here.
 */
`timescale 1ns/1ps
`include "flash_boot_regs.vh"
module flash_boot_loader_ram_overlay_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic boot_mode = 1'b1;
    logic flash_blank_done = 1'b0;
    logic flash_written = 1'b0;
    logic flash_erase_done = 1'b0;
    logic flash_erase_ok = 1'b0;
    logic [3:0] overlay_control_register = 4'h0;
    logic [31:0] cpu_addr = 32'h00000000;
    logic prog_req = 1'b0;
    logic erase_req = 1'b0;
    logic flash_busy = 1'b0;
    logic erase_seen = 1'b0;
    wire rxd, txd, serial_receive_enable, serial_transmit_enable, ram_wr_valid;
    wire flash_blank_check, flash_erase_all, jump_to_ram, boot_failed, overlay_hit;
    wire flash_program_go, flash_erase_go, flash_read_allow;
    wire [15:0] baud_divisor_register;
    wire [31:0] ram_wr_addr, jump_addr, mapped_addr;
    wire [7:0] ram_wr_data;
    logic [31:0] wa[$];
    logic [7:0] wd[$];
    int n_errors = 0;
    int n_compared = 0;
    always #10 clk = ~clk;
    // Forty clocks a bit, so the expected divisor is 39
    serial_host_model #(.BIT_NS(800)) host (.rxd, .txd);
    flash_boot_loader_ram_overlay DUT (.clk, .rst, .boot_mode, .rxd, .txd, .baud_divisor_register,
        .serial_receive_enable, .serial_transmit_enable, .ram_wr_addr, .ram_wr_data, .ram_wr_valid,
        .ram_wr_ready(1'b1), .flash_blank_check, .flash_blank_done, .flash_written, .flash_erase_all,
        .flash_erase_done, .flash_erase_ok, .jump_to_ram, .jump_addr, .boot_failed,
        .overlay_control_register, .cpu_addr, .mapped_addr, .overlay_hit, .prog_req, .erase_req,
        .flash_busy, .flash_program_go, .flash_erase_go, .flash_read_allow);
    always @(posedge clk) begin
        flash_blank_done <= #1 flash_blank_check && !flash_blank_done;
        flash_erase_done <= #1 flash_erase_all && !flash_erase_done;
        if (flash_erase_all) erase_seen <= #1 1'b1;
        if (ram_wr_valid) begin
            wa.push_back(ram_wr_addr);
            wd.push_back(ram_wr_data);
        end
    end
    ////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task do_reset(input logic mode);
        @(posedge clk);
        #1;
        rst = 1'b1;
        boot_mode = mode;
        erase_seen = 1'b0;
        wa.delete();
        wd.delete();
        host.rx_q.delete();
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
    endtask
    task get_byte(output logic [7:0] v);
        while (host.rx_q.size() == 0) @(posedge clk);
        v = host.rx_q.pop_front();
        @(posedge clk);
        #1;
    endtask
    task do_boot(input logic [15:0] n, input logic written, input logic ok);
        logic [7:0] v;
        do_reset(1'b1);
        flash_written = written;
        flash_erase_ok = ok;
        host.sync_rate();
        get_byte(v);
        check(v, 8'h00);
        check(baud_divisor_register, 16'h0027);
        host.send_byte(8'h55);
        get_byte(v);
        check(v, 8'hAA);
        for (int i = 1; i >= 0; i--) begin
            host.send_byte(n[i*8 +: 8]);
            get_byte(v);
            check(v, n[i*8 +: 8]);
        end
        for (int i = 0; i < n; i++) begin
            host.send_byte(8'hC3 ^ i[7:0]);
            get_byte(v);
            check(v, 8'hC3 ^ i[7:0]);
            check(wd[i], 8'hC3 ^ i[7:0]);
            check(wa[i], `BOOT_RAM_BASE + i);
        end
        check(wd.size(), n);
        get_byte(v);
        check(v, (ok || !written) ? 8'hAA : 8'hFF);
        for (int k = 0; k < 4000 && jump_to_ram !== 1'b1 && boot_failed !== 1'b1; k++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        check(erase_seen, written);
        check({jump_to_ram, boot_failed}, (ok || !written) ? 2'b10 : 2'b01);
    endtask
    ////////////////////////////////////////////////////////////
    task t_no_boot;
        do_reset(1'b0);
        repeat (3) host.send_byte(8'h00);
        repeat (400) @(posedge clk);
        check(host.rx_q.size(), 0);
        check({jump_to_ram, serial_receive_enable, serial_transmit_enable}, 3'b000);
    endtask
    task t_load_erase;
        do_boot(16'h0003, 1'b1, 1'b1);
        check(jump_addr, `BOOT_RAM_BASE);
        check({serial_receive_enable, serial_transmit_enable, txd}, 3'b001);
        check(baud_divisor_register, 16'h0027);
    endtask
    // Empty program straight after a jump: reset lands in mid-run
    task t_erase_fail;
        do_boot(16'h0000, 1'b1, 1'b0);
        repeat (600) @(posedge clk);
        check(host.rx_q.size(), 0);
    endtask
    task t_blank_flash;
        do_boot(16'h0001, 1'b0, 1'b0);
        check(flash_erase_all, 1'b0);
    endtask
    task probe(input logic [3:0] c, input logic [31:0] a);
        @(posedge clk);
        #1;
        overlay_control_register = c;
        cpu_addr = a;
        flash_busy = c[0];
        #5;
    endtask
    task t_overlay;
        prog_req = 1'b1;
        erase_req = 1'b1;
        // Block zero is decoded only; its vector table is software's job
        for (int s = 0; s < 8; s++) begin
            probe({1'b1, s[2:0]}, s * 32'h00001000 + 32'h00000ABC);
            check(overlay_hit, 1'b1);
            check(mapped_addr, 32'hFFFFEABC);
            check({flash_program_go, flash_erase_go}, 2'b00);
            check(flash_read_allow, !s[0]);
            probe({1'b1, s[2:0]}, (s ^ 1) * 32'h00001000 + 32'h00000ABC);
            check(overlay_hit, 1'b0);
            probe({1'b0, s[2:0]}, s * 32'h00001000 + 32'h00000ABC);
            check(overlay_hit, 1'b0);
            check(mapped_addr, s * 32'h00001000 + 32'h00000ABC);
            check({flash_program_go, flash_erase_go}, 2'b11);
        end
        probe(4'hF, 32'hFFFFE123);
        check(mapped_addr, 32'hFFFFE123);
    endtask
    initial begin
        t_no_boot();
        t_load_erase();
        t_erase_fail();
        t_blank_flash();
        t_overlay();
        finish_test();
    end
    // Nearly five times the expected run length
    initial begin
        #1_500_000;
        n_errors++;
        finish_test();
    end
endmodule
bind flash_boot_loader_ram_overlay boot_checker #(.DIV_W(DIV_W)) chk (.clk, .rst, .txd,
    .baud_divisor_register, .serial_receive_enable, .serial_transmit_enable, .ram_wr_addr,
    .ram_wr_valid, .flash_erase_all, .flash_erase_done, .jump_to_ram, .jump_addr,
    .overlay_control_register, .cpu_addr, .mapped_addr, .overlay_hit, .prog_req, .erase_req,
    .flash_busy, .flash_program_go, .flash_erase_go, .flash_read_allow);
